// ==== bench/psc_cfg_assertions.sv ====
// Concurrent checks on the configuration bank's ports.
`timescale 1ns/1ns
module psc_cfg_assertions (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        scl_in,
   input wire logic        sda_oe,
   input wire logic        align_in,
   input wire logic [11:0] ref_modulus,
   input wire logic        powerdown_a,
   input wire logic [3:0]  out_div_c_modulus,
   input wire logic [4:0]  out_div_a_modulus,
   input wire logic [4:0]  out_div_b_modulus,
   input wire logic [13:0] feedback_modulus,
   input wire logic        align_enable,
   input wire logic        align_edge_sel,
   input wire logic        align_pulse
);
   wire [30:0] cfg_view = {ref_modulus, powerdown_a, out_div_c_modulus, feedback_modulus};
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   reset_values_a: assert property ($fell(rst) |-> ref_modulus == 12'h0 && !sda_oe
      && feedback_modulus == 14'h0 && out_div_c_modulus == 4'h1 && !powerdown_a)
      else $error("fields not cleared by reset");
   field_update_a: assert property (!$stable(cfg_view) |-> sda_oe)
      else $error("field changed outside an acknowledge");
   ack_timing_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
      else $error("data line moved while clock high");
   align_single_a: assert property (align_pulse |=> !align_pulse)
      else $error("alignment pulse too long");
   align_gate_a: assert property (align_pulse |-> align_enable)
      else $error("alignment pulse while disabled");
   align_edge_a: assert property (align_pulse |-> $past(align_in, 2) == align_edge_sel
      && $past(align_in, 6) != align_edge_sel)
      else $error("alignment pulse on wrong edge");
   div_c_onehot_a: assert property ($onehot(out_div_c_modulus))
      else $error("third divider modulus not a power of two");
   div_ab_range_a: assert property (out_div_a_modulus inside {[5'h01:5'h0c]}
      && out_div_b_modulus inside {[5'h01:5'h0c]})
      else $error("divider modulus zero");
   ack_seen_c: cover property ($rose(sda_oe));
   align_rise_c: cover property (align_pulse && align_edge_sel);
   align_fall_c: cover property (align_pulse && !align_edge_sel);
endmodule

// ==== bench/psc_host.sv ====
// Two-wire bus host model for the configuration bank.
`timescale 1ns/1ns
module psc_host (
   input  wire logic  clock,
   input  wire logic  sda_wire,
   output logic       scl = 1'b1,
   output logic       sda_low = 1'b0,
   output logic       done = 1'b0,
   output logic [7:0] q = 8'h00
);
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // One clock period: data moves mid-low, the wire is read late in the high phase.
   task automatic phase(input logic a, input logic b, output logic r);
      scl <= 1'b0;
      tick(2);
      sda_low <= a;
      tick(3);
      scl <= 1'b1;
      tick(2);
      @(negedge clock) r = sda_wire;
      @(posedge clock) sda_low <= b;
   endtask
   // Start when s is high, stop when low; the data line moves while the clock is high.
   task automatic cond(input logic s);
      logic r;
      phase(!s, s, r);
      tick(4);
   endtask
   // Eight bits MSB first, then the ninth, pulled low by the host when mack is high.
   task automatic xfer(input logic [7:0] d, input logic mack, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         phase(!d[i], !d[i], r);
         q[i] <= r;
      end
      phase(mack, mack, r);
      ack = !r;
      done <= 1'b1;
      tick(1);
      done <= 1'b0;
   endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the synthesizer configuration bank.
`timescale 1ns/1ns
`include "psc_cfg_regs.vh"
module tb_top;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  addr_sel = 2'h0;
   logic        align_in = 1'b0;
   logic [63:0] img = 64'h0;
   logic [64:0] exp_q[$];
   logic [64:0] e;
   logic        ack;
   int          mismatches = 0;
   int          checked = 0;
   int          pulses = 0;
   int          base;
   wire         scl;
   wire         sda_low;
   wire         sda_oe;
   wire         sda_out;
   wire         host_done;
   wire  [7:0]  host_q;
   wire  [11:0] ref_modulus;
   wire         ref_source_sel;
   wire         powerdown_a;
   wire  [3:0]  out_div_c_modulus;
   wire  [4:0]  out_div_a_modulus;
   wire  [4:0]  out_div_b_modulus;
   wire  [13:0] feedback_modulus;
   wire         feedback_source_sel;
   wire         out_mode_single_ended;
   wire  [1:0]  pump_current_code;
   wire  [1:0]  filter_res_code;
   wire         filter_cap_sel;
   wire         align_enable;
   wire         align_edge_sel;
   wire         powerdown_b;
   wire         align_pulse;
   // Open-drain data line with its pull-up: either side may pull it low.
   wire         sda_wire = !(sda_low || (sda_oe && !sda_out));
   wire  [51:0] fields = {ref_modulus, ref_source_sel, powerdown_a, out_div_c_modulus,
      out_div_a_modulus, out_div_b_modulus, feedback_modulus, feedback_source_sel,
      out_mode_single_ended, pump_current_code, filter_res_code, filter_cap_sel, align_enable,
      align_edge_sel, powerdown_b};
   always #5 clock = ~clock;
   psc_host host (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low),
      .done(host_done), .q(host_q));
   psc_config_bank dut (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .align_in(align_in),
      .ref_modulus(ref_modulus), .ref_source_sel(ref_source_sel), .powerdown_a(powerdown_a),
      .out_div_c_modulus(out_div_c_modulus), .out_div_a_modulus(out_div_a_modulus),
      .out_div_b_modulus(out_div_b_modulus), .feedback_modulus(feedback_modulus),
      .feedback_source_sel(feedback_source_sel), .out_mode_single_ended(out_mode_single_ended),
      .pump_current_code(pump_current_code), .filter_res_code(filter_res_code),
      .filter_cap_sel(filter_cap_sel), .align_enable(align_enable),
      .align_edge_sel(align_edge_sel), .powerdown_b(powerdown_b), .align_pulse(align_pulse));
   function automatic logic [51:0] expf(input logic [63:0] c);
      return {c[11:0], c[12], c[13], 4'h1 << c[15:14], c[19:16] + 5'h1, c[23:20] + 5'h1,
         c[37:24], c[38], c[39], c[41:40], c[45:44], c[46], c[48], c[49], c[53]};
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      checked++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clock) if (align_pulse === 1'b1) pulses <= pulses + 1;
   always @(posedge clock) begin
      if (host_done === 1'b1 && exp_q.size() == 0) begin
         check(64'h0, 64'h1);
      end else if (host_done === 1'b1) begin
         e = exp_q.pop_front();
         if (e[64]) check({12'h0, fields}, e[63:0]);
         else check({56'h0, host_q}, e[63:0]);
      end
   end
   task automatic send(input logic [7:0] d, input logic rdb, input logic mack, input logic want);
      exp_q.push_back(rdb ? {1'b0, 56'h0, d} : {1'b1, 12'h0, expf(img)});
      host.xfer(rdb ? 8'hff : d, mack, ack);
      if (!rdb) check(64'(ack), 64'(want));
   endtask
   task automatic wr(input logic [2:0] p, input int n, input logic [7:0] fix);
      logic [7:0] v;
      host.cond(1'b1);
      send({`PSC_DEV_ADDR_HI, addr_sel, 1'b0}, 1'b0, 1'b0, 1'b1);
      send({5'h00, p}, 1'b0, 1'b0, 1'b1);
      repeat (n) begin
         v = (n == 1) ? fix : 8'($urandom);
         if (p == 3'h2 && v[3:0] > 4'hb) v[3:0] = 4'hb;
         if (p == 3'h2 && v[7:4] > 4'hb) v[7:4] = 4'hb;
         v &= (p == 3'h5) ? 8'h73 : (p == 3'h6) ? 8'h23 : (p == 3'h7) ? 8'h00 : 8'hff;
         img[p*8 +: 8] = v;
         send(v, 1'b0, 1'b0, 1'b1);
         p++;
      end
      host.cond(1'b0);
   endtask
   task automatic rd(input logic [2:0] p);
      host.cond(1'b1);
      send({`PSC_DEV_ADDR_HI, addr_sel, 1'b0}, 1'b0, 1'b0, 1'b1);
      send({5'h00, p}, 1'b0, 1'b0, 1'b1);
      host.cond(1'b1);
      send({`PSC_DEV_ADDR_HI, addr_sel, 1'b1}, 1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         send(img[p*8 +: 8], 1'b1, i < 7, 1'b1);
         p++;
      end
      host.cond(1'b0);
   endtask
   initial begin
      #900000;
      mismatches++;
      print_verdict();
   end
   initial begin
      void'($urandom(11676));
      addr_sel <= 2'($urandom);
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      repeat (6) @(posedge clock);
      check({12'h0, fields}, {12'h0, expf(img)});
      rd(3'h0);
      wr(3'h0, 8, 8'h00);
      rd(3'($urandom));
      wr(3'h6, 3, 8'h00);
      rd(3'h5);
      // A read straight after the start continues at the current pointer.
      host.cond(1'b1);
      send({`PSC_DEV_ADDR_HI, addr_sel, 1'b1}, 1'b0, 1'b0, 1'b1);
      send(img[8*5 +: 8], 1'b1, 1'b0, 1'b1);
      host.cond(1'b0);
      for (int k = 0; k < 4; k++) begin
         wr(3'h1, 1, {2'(k), 6'h15});
         wr(3'h5, 1, {1'b0, 1'(k), 2'(k), 2'h0, 2'(k)});
         wr(3'h6, 1, {6'h00, 2'(k)});
         base = pulses;
         align_in <= 1'b1;
         repeat (12) @(posedge clock);
         check(64'(pulses - base), 64'(k == 3));
         align_in <= 1'b0;
         repeat (12) @(posedge clock);
         check(64'(pulses - base), 64'((k == 3) + (k == 1)));
      end
      // A foreign address is left unacknowledged and nothing is stored.
      host.cond(1'b1);
      send({`PSC_DEV_ADDR_HI, ~addr_sel, 1'b0}, 1'b0, 1'b0, 1'b0);
      host.cond(1'b0);
      rst <= 1'b1;
      addr_sel <= ~addr_sel;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      img = 64'h0;
      repeat (6) @(posedge clock);
      rd(3'h2);
      check(64'(exp_q.size()), 64'h0);
      print_verdict();
   end
endmodule
bind psc_config_bank psc_cfg_assertions chk (.clock(clock), .rst(rst), .scl_in(scl_in),
   .sda_oe(sda_oe), .align_in(align_in), .ref_modulus(ref_modulus), .powerdown_a(powerdown_a),
   .out_div_c_modulus(out_div_c_modulus), .out_div_a_modulus(out_div_a_modulus),
   .out_div_b_modulus(out_div_b_modulus), .feedback_modulus(feedback_modulus),
   .align_enable(align_enable), .align_edge_sel(align_edge_sel), .align_pulse(align_pulse));

// ==== verilog/psc_cfg_regs.vh ====
// Field layout and protocol constants of the synthesizer configuration bank.
`ifndef PSC_CFG_REGS_VH
`define PSC_CFG_REGS_VH

// --------------------------------------------------------------------
// Register bytes
// --------------------------------------------------------------------
`define PSC_REG_REF_DIVIDER_LOW             3'h0
`define PSC_REG_REF_DIVIDER_HIGH_AND_CTRL   3'h1
`define PSC_REG_OUTPUT_DIVIDER_PAIR         3'h2
`define PSC_REG_FEEDBACK_DIV_LOW            3'h3
`define PSC_REG_FEEDBACK_DIV_HIGH_AND_MODE  3'h4
`define PSC_REG_LOOP_TUNING                 3'h5
`define PSC_REG_SYNC_AND_SHUTDOWN           3'h6
`define PSC_REG_RESERVED_TOP                3'h7
`define PSC_REG_COUNT                       8
`define PSC_REG_RESET                       8'h00

// --------------------------------------------------------------------
// Bit positions in the 64-bit configuration word
// --------------------------------------------------------------------
`define PSC_REF_MODULUS_MSB        11
`define PSC_REF_MODULUS_LSB        0
`define PSC_REF_SOURCE_SEL_BIT     12
`define PSC_POWERDOWN_A_BIT        13
`define PSC_OUT_DIV_C_MSB          15
`define PSC_OUT_DIV_C_LSB          14
`define PSC_OUT_DIV_A_MSB          19
`define PSC_OUT_DIV_A_LSB          16
`define PSC_OUT_DIV_B_MSB          23
`define PSC_OUT_DIV_B_LSB          20
`define PSC_FEEDBACK_MODULUS_MSB   37
`define PSC_FEEDBACK_MODULUS_LSB   24
`define PSC_FEEDBACK_SOURCE_BIT    38
`define PSC_OUT_MODE_BIT           39
`define PSC_PUMP_CURRENT_MSB       41
`define PSC_PUMP_CURRENT_LSB       40
`define PSC_FILTER_RES_MSB         45
`define PSC_FILTER_RES_LSB         44
`define PSC_FILTER_CAP_BIT         46
`define PSC_ALIGN_ENABLE_BIT       48
`define PSC_ALIGN_EDGE_BIT         49
`define PSC_POWERDOWN_B_BIT        53

// --------------------------------------------------------------------
// Serial slave
// --------------------------------------------------------------------
`define PSC_DEV_ADDR_HI            5'h0b
`define PSC_BITS_PER_BYTE          4'h8
`define PSC_BIT_ZERO               4'h0
`define PSC_BIT_ONE                4'h1
`define PSC_PTR_STEP               3'h1
`define PSC_SYNC_WIDTH             5

`endif

// ==== verilog/psc_config_bank.v ====
// Serially programmed configuration bank of the clock synthesizer.
//
// Behaviour
// - Reference source select: 0 crystal oscillator, 1 external reference pin.
// - Feedback source select: 0 oscillator core output, 1 post-divider chain.
// - Each shutdown bit: 0 normal operation, 1 section powered down.
// - Output mode: 0 differential emitter-coupled, 1 full-swing single-ended.
// - Two-bit filter resistor code, 00 largest down to 11 smallest.
// - Filter capacitor select: 0 smaller, 1 larger capacitance.
// - Reference modulus is 12-bit binary in configuration bits 11 to 0.
// - Feedback modulus is 14-bit binary in configuration bits 37 to 24.
// - Third post-divider is two bits at 15 and 14, modulus 1, 2, 4, 8.
// - Alignment enable: 0 ignores, 1 uses the synchronization input.
// - Alignment edge select: 0 falling edge, 1 rising edge.
// - Third post-divider codes 00, 01, 10, 11 give 1, 2, 4, 8.
// - Every configuration bit clears to zero at reset.
// - Every configuration bit reads back exactly as last written.
// - Each byte takes effect at its acknowledge, not at the stop condition.
`timescale 1ns/1ns
`include "psc_cfg_regs.vh"
module psc_config_bank (
   input  wire        clock,
   input  wire        rst,
   input  wire        scl_in,
   input  wire        sda_in,
   output reg         sda_out,
   output reg         sda_oe,
   input  wire [1:0]  addr_sel,
   input  wire        align_in,
   output reg  [11:0] ref_modulus,
   output reg         ref_source_sel,
   output reg         powerdown_a,
   output reg  [3:0]  out_div_c_modulus,
   output reg  [4:0]  out_div_a_modulus,
   output reg  [4:0]  out_div_b_modulus,
   output reg  [13:0] feedback_modulus,
   output reg         feedback_source_sel,
   output reg         out_mode_single_ended,
   output reg  [1:0]  pump_current_code,
   output reg  [1:0]  filter_res_code,
   output reg         filter_cap_sel,
   output reg         align_enable,
   output reg         align_edge_sel,
   output reg         powerdown_b,
   output reg         align_pulse
);

   // -----------------------------------------------------------------
   // States
   // -----------------------------------------------------------------
   localparam ST_IDLE = 4'h0;
   localparam ST_ADDR = 4'h1;
   localparam ST_AACK = 4'h2;
   localparam ST_PTR  = 4'h3;
   localparam ST_PACK = 4'h4;
   localparam ST_WDAT = 4'h5;
   localparam ST_WACK = 4'h6;
   localparam ST_RDAT = 4'h7;
   localparam ST_RACK = 4'h8;

   // -----------------------------------------------------------------
   // Pin synchronisation and edge detection
   // -----------------------------------------------------------------
   wire [`PSC_SYNC_WIDTH-1:0] pins_s;
   reg                        scl_d;
   reg                        sda_d;
   reg                        align_d;

   psc_sync #(
      .WIDTH    (`PSC_SYNC_WIDTH)
   ) u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in ({addr_sel, align_in, sda_in, scl_in}),
      .sync_out (pins_s)
   );

   wire       scl_s     = pins_s[0];
   wire       sda_s     = pins_s[1];
   wire       align_s   = pins_s[2];
   wire [1:0] addr_s    = pins_s[4:3];
   wire       scl_rise  = scl_s & ~scl_d;
   wire       scl_fall  = ~scl_s & scl_d;
   wire       bus_start = scl_s & scl_d & sda_d & ~sda_s;
   wire       bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

   // -----------------------------------------------------------------
   // Configuration storage
   // -----------------------------------------------------------------
   reg  [7:0]  cfg [0:`PSC_REG_COUNT-1];
   reg  [3:0]  state;
   reg  [3:0]  bitcnt;
   reg  [7:0]  shift;
   reg  [7:0]  tx;
   reg  [2:0]  ptr;
   reg         rw;
   reg         nack;
   wire [63:0] cfg_flat = {cfg[7], cfg[6], cfg[5], cfg[4], cfg[3], cfg[2], cfg[1], cfg[0]};
   wire        byte_done = (bitcnt == `PSC_BITS_PER_BYTE);
   wire [6:0]  dev_addr  = {`PSC_DEV_ADDR_HI, addr_s};
   integer     k;

   // -----------------------------------------------------------------
   // Serial slave engine
   // -----------------------------------------------------------------
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         for (k = 0; k < `PSC_REG_COUNT; k = k + 1) begin
            cfg[k] <= `PSC_REG_RESET;
         end
         state   <= ST_IDLE;
         bitcnt  <= `PSC_BIT_ZERO;
         shift   <= 8'h00;
         tx      <= 8'h00;
         ptr     <= 3'h0;
         rw      <= 1'b0;
         nack    <= 1'b0;
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
         scl_d   <= 1'b1;
         sda_d   <= 1'b1;
      end else begin
         scl_d   <= scl_s;
         sda_d   <= sda_s;
         sda_out <= 1'b0;
         if (bus_start) begin
            state  <= ST_ADDR;
            bitcnt <= `PSC_BIT_ZERO;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            case (state)
               ST_ADDR, ST_PTR, ST_WDAT: begin
                  shift  <= {shift[6:0], sda_s};
                  bitcnt <= bitcnt + `PSC_BIT_ONE;
               end
               ST_RDAT: begin
                  bitcnt <= bitcnt + `PSC_BIT_ONE;
               end
               ST_RACK: begin
                  nack <= sda_s;
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (state)
               ST_ADDR: begin
                  if (byte_done && shift[7:1] == dev_addr) begin
                     rw     <= shift[0];
                     sda_oe <= 1'b1;
                     state  <= ST_AACK;
                  end else if (byte_done) begin
                     state <= ST_IDLE;
                  end
               end
               ST_AACK: begin
                  bitcnt <= `PSC_BIT_ZERO;
                  if (rw) begin
                     tx     <= cfg[ptr];
                     sda_oe <= ~cfg[ptr][7];
                     state  <= ST_RDAT;
                  end else begin
                     sda_oe <= 1'b0;
                     state  <= ST_PTR;
                  end
               end
               ST_PTR: begin
                  if (byte_done) begin
                     ptr    <= shift[2:0];
                     sda_oe <= 1'b1;
                     state  <= ST_PACK;
                  end
               end
               ST_PACK, ST_WACK: begin
                  sda_oe <= 1'b0;
                  bitcnt <= `PSC_BIT_ZERO;
                  state  <= ST_WDAT;
               end
               ST_WDAT: begin
                  if (byte_done) begin
                     cfg[ptr] <= shift;
                     ptr      <= ptr + `PSC_PTR_STEP;
                     sda_oe   <= 1'b1;
                     state    <= ST_WACK;
                  end
               end
               ST_RDAT: begin
                  if (byte_done) begin
                     sda_oe <= 1'b0;
                     ptr    <= ptr + `PSC_PTR_STEP;
                     state  <= ST_RACK;
                  end else begin
                     tx     <= {tx[6:0], 1'b0};
                     sda_oe <= ~tx[6];
                  end
               end
               ST_RACK: begin
                  bitcnt <= `PSC_BIT_ZERO;
                  if (nack) begin
                     state <= ST_IDLE;
                  end else begin
                     tx     <= cfg[ptr];
                     sda_oe <= ~cfg[ptr][7];
                     state  <= ST_RDAT;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Field outputs to the synthesizer core
   // -----------------------------------------------------------------
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ref_modulus           <= 12'h000;
         ref_source_sel        <= 1'b0;
         powerdown_a           <= 1'b0;
         out_div_c_modulus     <= 4'h1;
         out_div_a_modulus     <= 5'h01;
         out_div_b_modulus     <= 5'h01;
         feedback_modulus      <= 14'h0000;
         feedback_source_sel   <= 1'b0;
         out_mode_single_ended <= 1'b0;
         pump_current_code     <= 2'h0;
         filter_res_code       <= 2'h0;
         filter_cap_sel        <= 1'b0;
         align_enable          <= 1'b0;
         align_edge_sel        <= 1'b0;
         powerdown_b           <= 1'b0;
      end else begin
         ref_modulus           <= cfg_flat[`PSC_REF_MODULUS_MSB:`PSC_REF_MODULUS_LSB];
         ref_source_sel        <= cfg_flat[`PSC_REF_SOURCE_SEL_BIT];
         powerdown_a           <= cfg_flat[`PSC_POWERDOWN_A_BIT];
         powerdown_b           <= cfg_flat[`PSC_POWERDOWN_B_BIT];
         out_div_c_modulus     <= 4'h1
                                  << cfg_flat[`PSC_OUT_DIV_C_MSB:`PSC_OUT_DIV_C_LSB];
         out_div_a_modulus     <= {1'b0, cfg_flat[`PSC_OUT_DIV_A_MSB:`PSC_OUT_DIV_A_LSB]}
                                  + 5'h01;
         out_div_b_modulus     <= {1'b0, cfg_flat[`PSC_OUT_DIV_B_MSB:`PSC_OUT_DIV_B_LSB]}
                                  + 5'h01;
         feedback_modulus      <= cfg_flat[`PSC_FEEDBACK_MODULUS_MSB:
                                           `PSC_FEEDBACK_MODULUS_LSB];
         feedback_source_sel   <= cfg_flat[`PSC_FEEDBACK_SOURCE_BIT];
         out_mode_single_ended <= cfg_flat[`PSC_OUT_MODE_BIT];
         pump_current_code     <= cfg_flat[`PSC_PUMP_CURRENT_MSB:`PSC_PUMP_CURRENT_LSB];
         filter_res_code       <= cfg_flat[`PSC_FILTER_RES_MSB:`PSC_FILTER_RES_LSB];
         filter_cap_sel        <= cfg_flat[`PSC_FILTER_CAP_BIT];
         align_enable          <= cfg_flat[`PSC_ALIGN_ENABLE_BIT];
         align_edge_sel        <= cfg_flat[`PSC_ALIGN_EDGE_BIT];
      end
   end

   // -----------------------------------------------------------------
   // Synchronization input edge detection
   // -----------------------------------------------------------------
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         align_d     <= 1'b0;
         align_pulse <= 1'b0;
      end else begin
         align_d <= align_s;
         if (cfg_flat[`PSC_ALIGN_EDGE_BIT]) begin
            align_pulse <= cfg_flat[`PSC_ALIGN_ENABLE_BIT] & align_s & ~align_d;
         end else begin
            align_pulse <= cfg_flat[`PSC_ALIGN_ENABLE_BIT] & ~align_s & align_d;
         end
      end
   end

endmodule

// ==== verilog/psc_sync.v ====
// Two-stage synchroniser for the asynchronous input pins.
`timescale 1ns/1ns
module psc_sync #(
   parameter WIDTH = 1
) (
   input  wire             clock,
   input  wire             rst,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage_a;
   reg [WIDTH-1:0] stage_b;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               stage_a[i] <= 1'b0;
               stage_b[i] <= 1'b0;
            end else begin
               stage_a[i] <= async_in[i];
               stage_b[i] <= stage_a[i];
            end
         end
      end
   endgenerate

   assign sync_out = stage_b;

endmodule
